/* core/swd_pkg.sv */
// shared constants and helpers of the single-wire debug command link
package swd_pkg;
   // command opcodes
   localparam logic [7:0] OP_BACKGROUND = 8'h90;
   localparam logic [7:0] OP_READ_BYTE_DEBUG_MAPPED = 8'hE4;
   localparam logic [7:0] OP_READ_WORD_DEBUG_MAPPED = 8'hEC;
   localparam logic [7:0] OP_READ_BYTE_PLAIN = 8'hE0;
   localparam logic [7:0] OP_READ_WORD_PLAIN = 8'hE8;
   localparam logic [7:0] OP_WRITE_BYTE_DEBUG_MAPPED = 8'hC4;
   localparam logic [7:0] OP_WRITE_WORD_DEBUG_MAPPED = 8'hCC;
   localparam logic [7:0] OP_WRITE_BYTE_PLAIN = 8'hC0;
   localparam logic [7:0] OP_WRITE_WORD_PLAIN = 8'hC8;
   localparam logic [7:0] OP_READ_NEXT_WORD = 8'h62;
   localparam logic [7:0] OP_READ_STACK_POINTER = 8'h67;
   localparam logic [7:0] OP_WRITE_NEXT_WORD = 8'h42;
   localparam logic [7:0] OP_WRITE_STACK_POINTER = 8'h47;
   localparam logic [7:0] OP_RESUME = 8'h08;
   localparam logic [7:0] OP_SINGLE_STEP_CMD = 8'h10;
   localparam logic [7:0] OP_TAG_AND_RESUME_CMD = 8'h18;
   // cpu register index (opcode low bits) of the x index register
   localparam logic [2:0] REG_IDX_X = 3'h5;
   localparam logic [15:0] NEXT_WORD_STEP = 16'h0002;
   // debug resource windows while mapped in
   localparam logic [15:0] DEBUG_REG_LO = 16'hFF00;
   localparam logic [15:0] DEBUG_REG_HI = 16'hFF06;
   localparam logic [15:0] DEBUG_ROM_LO = 16'hFF20;
   localparam logic [15:0] DEBUG_ROM_HI = 16'hFFFF;
   // serial timing in debug clock cycles
   localparam logic [4:0] BIT_CYCLES = 5'h10;
   localparam logic [4:0] SAMPLE_CYCLE = 5'h0A;
   localparam logic [4:0] TX_ONE_PULSE = 5'h07;
   localparam logic [4:0] TX_ZERO_LOW = 5'h0D;
   localparam logic [4:0] HOST_ONE_LOW = 5'h04;
   localparam logic [4:0] HOST_RX_LOW = 5'h02;
   localparam logic [9:0] TIMEOUT_CYCLES = 10'h200;
   localparam logic [7:0] STEAL_CYCLES = 8'h80;
   localparam logic [7:0] HOST_HW_GAP = 8'h96;
   localparam logic [7:0] HOST_FW_GAP = 8'h20;
   localparam logic [7:0] HOST_RESUME_GAP = 8'h40;
   localparam logic [7:0] HOST_TAIL_GAP = 8'h04;

   function automatic logic is_hw(input logic [7:0] op);
      is_hw = (op[7:4] == 4'hC || op[7:4] == 4'hE) && op[1:0] == 2'h0;
   endfunction : is_hw

   function automatic logic hw_write(input logic [7:0] op);
      hw_write = op[7:4] == 4'hC;
   endfunction : hw_write

   function automatic logic fw_read(input logic [7:0] op);
      fw_read = op >= OP_READ_NEXT_WORD && op <= OP_READ_STACK_POINTER;
   endfunction : fw_read

   function automatic logic fw_write(input logic [7:0] op);
      fw_write = op >= OP_WRITE_NEXT_WORD && op <= OP_WRITE_STACK_POINTER;
   endfunction : fw_write

   function automatic logic in_range(input logic [15:0] a,
      input logic [15:0] lo, input logic [15:0] hi);
      in_range = a >= lo && a <= hi;
   endfunction : in_range
endpackage : swd_pkg

/* core/swd_if.sv */
// single-wire debug pin with both drivers and a pull-up
`timescale 1ns/1ps
interface swd_if;
   logic host_o;
   logic host_oe;
   logic dev_o;
   logic dev_oe;
   logic pin_level;

   // pulled high unless a driver pulls low
   assign pin_level = !((host_oe && !host_o) || (dev_oe && !dev_o));

   modport device (input pin_level, output dev_o, output dev_oe);
   modport host (input pin_level, output host_o, output host_oe);
endinterface : swd_if

/* core/swd_device.sv */
// device end of the single-wire debug command link
// Summary of operation
// [RULE1] opcode 90 enters background if firmware enabled
// [RULE2] E4/EC/E0/E8 read memory, mapped in or out
// [RULE3] C4/CC/C0/C8 write memory, mapped in or out
// [RULE4] odd byte low lane, even byte high
// [RULE5] host sends word accesses word aligned only
// [RULE6] debug resources mapped only during access cycles
// [RULE7] firmware commands only while in background
// [RULE8] background maps rom FF20-FFFF, regs FF00-FF06
// [RULE9] 62-67 read next word or cpu register
// [RULE10] 42-47 write next word or cpu register
// [RULE11] next-word commands add 2 to x first
// [RULE12] 08 resume, 10 single step, 18 tag+resume
// [RULE13] opcode then optional address and/or data
// [RULE14] every read returns a full 16-bit word
// [RULE15] host waits 150 cycles around hardware access
// [RULE16] bus access within 128 cycles, else steal
// [RULE17] host waits 32 cycles before firmware readback
// [RULE18] msb first, 16 cycles/bit, host edge starts
// [RULE19] 512 cycles without edge clears command
// [RULE20] background request without enable just resumes; code ignores it and pulses no resume
// [RULE21] host waits 64 cycles after resume/step
// [RULE22] unknown opcodes do nothing
`timescale 1ns/1ps
module swd_device (
   input wire logic clk,
   input wire logic rst_n,
   swd_if.device link,
   input wire logic firmware_debug_enable,
   input wire logic cpu_break,
   input wire logic bus_free,
   input wire logic mem_ack,
   input wire logic [15:0] mem_rdata,
   input wire logic [15:0] cpu_reg_rdata,
   output logic background_debug,
   output logic mem_req,
   output logic mem_we,
   output logic [1:0] mem_be,
   output logic [15:0] mem_addr,
   output logic [15:0] mem_wdata,
   output logic mem_steal,
   output logic debug_rom_sel,
   output logic debug_reg_sel,
   output logic [2:0] cpu_reg_sel,
   output logic cpu_reg_we,
   output logic [15:0] cpu_reg_wdata,
   output logic resume,
   output logic single_step,
   output logic tag_enable
);
   typedef enum logic [6:0] {
      S_OP = 7'h01,
      S_ADDR = 7'h02,
      S_WDATA = 7'h04,
      S_BUS = 7'h08,
      S_FWRD = 7'h10,
      S_XINC = 7'h20,
      S_SEND = 7'h40
   } swd_state_t;

   swd_state_t state;
   swd_state_t next_state;
   logic pin_q;
   logic [4:0] cnt;
   logic [9:0] idle_cnt;
   logic [15:0] rx;
   logic [4:0] nbits;
   logic [7:0] op;
   logic [15:0] tx;
   logic cur_bit;
   logic [7:0] wait_cnt;

   ////////////////////////////////////////////////////////////////////////
   // serial bit timing
   wire fall = pin_q && !link.pin_level;
   wire sample = cnt == swd_pkg::SAMPLE_CYCLE;
   wire timeout = idle_cnt == swd_pkg::TIMEOUT_CYCLES - 10'h001;
   wire receiving = state == S_OP || state == S_ADDR || state == S_WDATA;
   wire rx_bit = sample && receiving;
   wire [15:0] word = {rx[14:0], link.pin_level};
   wire [7:0] new_op = word[7:0];
   wire byte_done = rx_bit && state == S_OP && nbits == 5'h07;
   wire word_done = rx_bit && state != S_OP && nbits == 5'h0F;
   wire tx_step = state == S_SEND && fall;
   wire bit_over = cnt == swd_pkg::BIT_CYCLES;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pin_q <= 1'b1;
         cnt <= swd_pkg::BIT_CYCLES;
         idle_cnt <= 10'h000;
      end
      else
      begin
         pin_q <= link.pin_level;
         // bit time starts at each host falling edge
         cnt <= fall ? 5'h00 : (bit_over ? cnt : cnt + 5'h01); // [RULE18]
         if (fall)
            idle_cnt <= 10'h000;
         else if (idle_cnt != swd_pkg::TIMEOUT_CYCLES)
            idle_cnt <= idle_cnt + 10'h001; // [RULE19]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // command decode
   wire in_bg = background_debug;
   wire op_hw = swd_pkg::is_hw(op);
   wire new_next = new_op == swd_pkg::OP_READ_NEXT_WORD ||
      new_op == swd_pkg::OP_WRITE_NEXT_WORD;
   wire op_next = op == swd_pkg::OP_READ_NEXT_WORD ||
      op == swd_pkg::OP_WRITE_NEXT_WORD;
   wire fw_rd = in_bg && swd_pkg::fw_read(new_op); // [RULE7]
   wire fw_wr = in_bg && swd_pkg::fw_write(new_op); // [RULE7]
   wire go_cmd = in_bg && new_op == swd_pkg::OP_RESUME;
   wire step_cmd = in_bg && new_op == swd_pkg::OP_SINGLE_STEP_CMD;
   wire tag_cmd = in_bg && new_op == swd_pkg::OP_TAG_AND_RESUME_CMD;
   wire bg_req = new_op == swd_pkg::OP_BACKGROUND;
   wire acc_write = (op_hw && swd_pkg::hw_write(op)) ||
      op == swd_pkg::OP_WRITE_NEXT_WORD;
   wire acc_byte = op_hw && !op[3];
   wire acc_mapped = (op_hw && op[2]) || in_bg; // [RULE6] [RULE8]
   wire [1:0] lanes = !acc_byte ? 2'h3 : (mem_addr[0] ? 2'h1 : 2'h2);
   wire [15:0] rd_word = {mem_rdata[15:8] & {8{mem_be[1]}},
      mem_rdata[7:0] & {8{mem_be[0]}}}; // [RULE4] [RULE14]
   wire issue = state == S_BUS && !mem_req &&
      (bus_free || wait_cnt == swd_pkg::STEAL_CYCLES - 8'h01);
   wire done_acc = mem_req && mem_ack;
   wire [15:0] x_plus = cpu_reg_rdata + swd_pkg::NEXT_WORD_STEP;
   wire fw_reg_write = word_done && state == S_WDATA && !op_hw && !op_next;

   always_comb
   begin
      next_state = state;
      unique case (state)
         S_OP:
            if (byte_done)
            begin
               if (swd_pkg::is_hw(new_op))
                  next_state = S_ADDR; // [RULE2] [RULE3] [RULE13]
               else if (fw_rd)
                  next_state = S_FWRD; // [RULE9]
               else if (fw_wr)
                  next_state = S_WDATA; // [RULE10]
               else
                  next_state = S_OP; // [RULE22]
            end
         S_ADDR:
            if (word_done)
               next_state = swd_pkg::hw_write(op) ? S_WDATA : S_BUS;
         S_WDATA:
            if (word_done)
               next_state = op_hw ? S_BUS : (op_next ? S_XINC : S_OP);
         S_BUS:
            if (done_acc)
               next_state = acc_write ? S_OP : S_SEND;
         S_FWRD:
            next_state = op_next ? S_XINC : S_SEND;
         S_XINC:
            next_state = S_BUS;
         S_SEND:
            if (nbits == 5'h10 && bit_over)
               next_state = S_OP;
      endcase
      if (timeout && (receiving || state == S_SEND))
         next_state = S_OP; // [RULE19]
   end

   ////////////////////////////////////////////////////////////////////////
   // shifters and command register
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state <= S_OP;
         nbits <= 5'h00;
         rx <= 16'h0000;
         op <= 8'h00;
      end
      else
      begin
         state <= next_state;
         if (next_state != state || byte_done || timeout)
            nbits <= 5'h00;
         else if (rx_bit || tx_step)
            nbits <= nbits + 5'h01;
         if (rx_bit)
            rx <= word; // [RULE18]
         if (timeout)
            op <= 8'h00; // [RULE19]
         else if (byte_done)
            op <= new_op;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         tx <= 16'h0000;
         cur_bit <= 1'b1;
      end
      else if (state == S_FWRD && !op_next)
         tx <= cpu_reg_rdata; // [RULE9] [RULE14]
      else if (state == S_BUS && done_acc)
         tx <= rd_word; // [RULE2] [RULE14]
      else if (tx_step)
      begin
         cur_bit <= tx[15]; // [RULE18]
         tx <= {tx[14:0], 1'b0};
      end
   end

   // answer bit: low for zero then speed-up high, or short high for one
   wire drive_zero = !cur_bit && cnt <= swd_pkg::TX_ZERO_LOW;
   wire drive_one = cur_bit && cnt == swd_pkg::TX_ONE_PULSE;
   wire tx_live = state == S_SEND && nbits != 5'h00;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         link.dev_oe <= 1'b0;
         link.dev_o <= 1'b1;
      end
      else
      begin
         link.dev_oe <= tx_live && (drive_zero || drive_one); // [RULE18]
         link.dev_o <= cur_bit || cnt == swd_pkg::TX_ZERO_LOW;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // target bus access
   always_ff @(posedge clk)
   begin
      if (!rst_n || state != S_BUS || mem_req)
         wait_cnt <= 8'h00;
      else
         wait_cnt <= wait_cnt + 8'h01; // [RULE16]
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         mem_req <= 1'b0;
         mem_steal <= 1'b0;
         mem_we <= 1'b0;
         mem_be <= 2'h0;
         debug_rom_sel <= 1'b0;
         debug_reg_sel <= 1'b0;
      end
      else if (issue)
      begin
         mem_req <= 1'b1;
         mem_steal <= !bus_free; // [RULE16]
         mem_we <= acc_write; // [RULE3] [RULE10]
         mem_be <= lanes; // [RULE4]
         debug_rom_sel <= acc_mapped && swd_pkg::in_range(mem_addr,
            swd_pkg::DEBUG_ROM_LO, swd_pkg::DEBUG_ROM_HI); // [RULE6]
         debug_reg_sel <= acc_mapped && swd_pkg::in_range(mem_addr,
            swd_pkg::DEBUG_REG_LO, swd_pkg::DEBUG_REG_HI); // [RULE6]
      end
      else if (done_acc)
      begin
         mem_req <= 1'b0;
         mem_steal <= 1'b0;
         debug_rom_sel <= 1'b0;
         debug_reg_sel <= 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         mem_addr <= 16'h0000;
         mem_wdata <= 16'h0000;
      end
      else if (word_done && state == S_ADDR)
         mem_addr <= word; // [RULE13]
      else if (state == S_XINC)
         mem_addr <= x_plus; // [RULE11]
      else if (word_done && state == S_WDATA)
         mem_wdata <= word;
   end

   ////////////////////////////////////////////////////////////////////////
   // cpu register port
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cpu_reg_sel <= 3'h0;
         cpu_reg_we <= 1'b0;
         cpu_reg_wdata <= 16'h0000;
      end
      else
      begin
         if (byte_done)
            cpu_reg_sel <= new_next ? swd_pkg::REG_IDX_X : new_op[2:0];
         cpu_reg_we <= fw_reg_write || state == S_XINC; // [RULE10] [RULE11]
         if (state == S_XINC)
            cpu_reg_wdata <= x_plus; // [RULE11]
         else if (fw_reg_write)
            cpu_reg_wdata <= word; // [RULE10]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // background mode and exit to user code
   wire bg_set = firmware_debug_enable &&
      ((byte_done && bg_req) || cpu_break); // [RULE1] [RULE20]
   wire bg_clr = byte_done && (go_cmd || step_cmd || tag_cmd);

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         background_debug <= 1'b0;
         resume <= 1'b0;
         single_step <= 1'b0;
         tag_enable <= 1'b0;
      end
      else
      begin
         if (bg_set)
            background_debug <= 1'b1; // [RULE1]
         else if (bg_clr)
            background_debug <= 1'b0; // [RULE12]
         resume <= byte_done && (go_cmd || tag_cmd); // [RULE12]
         single_step <= byte_done && step_cmd; // [RULE12]
         tag_enable <= byte_done && tag_cmd; // [RULE12]
      end
   end
endmodule : swd_device

/* core/swd_host.sv */
// host end of the single-wire debug command link
`timescale 1ns/1ps
module swd_host (
   input wire logic clk,
   input wire logic rst_n,
   swd_if.host link,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_op,
   input wire logic [15:0] cmd_addr,
   input wire logic [15:0] cmd_wdata,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic [15:0] rsp_data
);
   typedef enum logic [3:0] {
      H_IDLE = 4'h1,
      H_SEND = 4'h2,
      H_GAP = 4'h4,
      H_RECV = 4'h8
   } swd_hstate_t;

   swd_hstate_t state;
   logic [39:0] tx;
   logic [5:0] nbits;
   logic [4:0] c;
   logic [7:0] gap;
   logic rd;
   logic rd_pending;

   ////////////////////////////////////////////////////////////////////////
   // command framing
   wire c_hw = swd_pkg::is_hw(cmd_op);
   wire c_hw_wr = c_hw && swd_pkg::hw_write(cmd_op);
   wire c_fw_rd = swd_pkg::fw_read(cmd_op);
   wire c_fw_wr = swd_pkg::fw_write(cmd_op);
   wire c_exit = cmd_op == swd_pkg::OP_RESUME ||
      cmd_op == swd_pkg::OP_SINGLE_STEP_CMD ||
      cmd_op == swd_pkg::OP_TAG_AND_RESUME_CMD;
   wire [5:0] c_bits = c_hw_wr ? 6'h28 :
      ((c_hw || c_fw_wr) ? 6'h18 : 6'h08); // [RULE13]
   wire [39:0] c_frame = c_fw_wr ? {cmd_op, cmd_wdata, 16'h0000} :
      {cmd_op, cmd_addr, cmd_wdata};
   wire [7:0] c_gap = c_exit ? swd_pkg::HOST_RESUME_GAP : // [RULE21]
      ((c_fw_rd || c_fw_wr) ? swd_pkg::HOST_FW_GAP : // [RULE17]
      swd_pkg::HOST_HW_GAP); // [RULE15]
   wire start = state == H_IDLE && cmd_valid && cmd_ready;
   wire bit_end = c == swd_pkg::BIT_CYCLES - 5'h01;
   wire last_bit = bit_end && nbits == 6'h01;
   wire one_bit = tx[39];
   wire sample = state == H_RECV && c == swd_pkg::SAMPLE_CYCLE;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state <= H_IDLE;
         tx <= 40'h0;
         nbits <= 6'h00;
         c <= 5'h00;
         gap <= 8'h00;
         rd <= 1'b0;
         rd_pending <= 1'b0;
      end
      else
      begin
         c <= (state == H_SEND || state == H_RECV) && !bit_end ?
            c + 5'h01 : 5'h00;
         unique case (state)
            H_IDLE:
               if (start)
               begin
                  state <= H_SEND;
                  tx <= c_frame;
                  nbits <= c_bits;
                  gap <= c_gap;
                  rd <= c_fw_rd || (c_hw && !c_hw_wr);
               end
            H_SEND:
               if (bit_end)
               begin
                  tx <= {tx[38:0], 1'b0}; // [RULE18]
                  nbits <= nbits - 6'h01;
                  if (last_bit)
                     state <= H_GAP;
               end
            H_GAP:
               if (gap != 8'h00)
                  gap <= gap - 8'h01;
               else if (rd)
               begin
                  state <= H_RECV;
                  rd <= 1'b0;
                  nbits <= 6'h10; // [RULE14]
               end
               else
                  state <= H_IDLE;
            H_RECV:
               if (bit_end)
               begin
                  nbits <= nbits - 6'h01;
                  if (last_bit)
                  begin
                     state <= H_GAP;
                     gap <= swd_pkg::HOST_TAIL_GAP;
                  end
               end
         endcase
         rd_pending <= state == H_RECV && last_bit;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin drive and readback
   wire [4:0] low_len = one_bit ? swd_pkg::HOST_ONE_LOW :
      swd_pkg::TX_ZERO_LOW;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         link.host_oe <= 1'b0;
         link.host_o <= 1'b1;
         cmd_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data <= 16'h0000;
      end
      else
      begin
         link.host_oe <= state == H_SEND ||
            (state == H_RECV && c < swd_pkg::HOST_RX_LOW); // [RULE18]
         link.host_o <= state == H_SEND && c >= low_len;
         cmd_ready <= state == H_IDLE && !start;
         if (sample)
            rsp_data <= {rsp_data[14:0], link.pin_level}; // [RULE18]
         rsp_valid <= rd_pending;
      end
   end
endmodule : swd_host

/* verif/swd_link_checker.sv */
// wire-level assertions of the single-wire debug link
`timescale 1ns/1ps
module swd_link_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic host_o,
   input wire logic host_oe,
   input wire logic dev_o,
   input wire logic dev_oe,
   input wire logic pin_level
);
   logic [4:0] dlow;
   logic [4:0] hlow;
   logic [4:0] gap;
   logic hl_q;
   wire dl = dev_oe && !dev_o;
   wire dh = dev_oe && dev_o;
   wire hl = host_oe && !host_o;
   wire hfall = hl && !hl_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////
   // low runs and cycles since host fall
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         dlow <= 5'h00;
         hlow <= 5'h00;
         gap <= 5'h1F;
         hl_q <= 1'b0;
      end
      else
      begin
         dlow <= dl ? dlow + 5'h01 : 5'h00;
         hlow <= hl ? hlow + 5'h01 : 5'h00;
         gap <= hfall ? 5'h00 : (gap == 5'h1F ? gap : gap + 5'h01);
         hl_q <= hl;
      end
   end
   ////////////////////////
   no_fight_a: assert property (!(host_oe && dev_oe))
      else $error("both ends drive the pin");
   dev_zero_len_a: assert property ($fell(dl) |-> dlow == 5'h0D)
      else $error("device zero low time wrong");
   dev_zero_tail_a: assert property ($fell(dl) |-> dh)
      else $error("no speed-up after device zero");
   dev_pulse_a: assert property (dh |=> !dh)
      else $error("device high pulse too long");
   host_low_a: assert property
      ($fell(hl) |-> hlow inside {5'h02, 5'h04, 5'h0D})
      else $error("host low time wrong");
   host_release_a: assert property (hfall |-> ##[1:13] !hl)
      else $error("host holds pin low too long");
   bit_spacing_a: assert property (hfall |-> gap >= 5'h0F)
      else $error("host bits closer than a bit time");
   dev_in_bit_a: assert property (dev_oe |-> gap <= 5'h0F)
      else $error("device drives outside a bit time");
   pin_pull_a: assert property (!host_oe && !dev_oe |-> pin_level)
      else $error("released pin not high");
   reset_idle_a: assert property
      ($rose(rst_n) |-> !host_oe && !dev_oe)
      else $error("pin driven after reset");
   zero_bit_c: cover property ($fell(dl));
   one_bit_c: cover property (dh && !$past(dl));
   host_zero_c: cover property ($fell(hl) && hlow == 5'h0D);
endmodule : swd_link_checker

/* verif/testbench.sv */
// self-checking bench joining both ends of the debug link
`timescale 1ns/1ps
`define CHK(g, e) \
   begin \
      checks_done++; \
      if ((g) !== (e)) \
      begin \
         miscompares++; \
         $display("mismatch at %0t: %h vs %h", $time, g, e); \
      end \
   end
module testbench;
   logic clk, rst_n, cmd_valid, cmd_ready, rsp_valid, cpu_break, bus_free;
   logic mem_ack, background_debug, mem_req, mem_we, mem_steal;
   logic debug_rom_sel, debug_reg_sel, cpu_reg_we, resume, single_step;
   logic tag_enable, firmware_debug_enable, bg, hold_bus, steal_seen;
   logic [1:0] mem_be;
   logic [2:0] cpu_reg_sel;
   logic [7:0] cmd_op, op;
   logic [15:0] cmd_addr, cmd_wdata, rsp_data, mem_rdata, cpu_reg_rdata;
   logic [15:0] mem_addr, mem_wdata, cpu_reg_wdata, rnd, a, d, e, mw;
   logic [15:0] mem [0:65535], shd [0:65535], cpu_r [0:7];
   logic [15:0] expq [$];
   int miscompares, checks_done, n_acc, n_res, n_step, n_tag, k;
   swd_if link_if ();
   swd_device swd_device_inst (.clk, .rst_n, .link(link_if),
      .firmware_debug_enable, .cpu_break, .bus_free, .mem_ack, .mem_rdata,
      .cpu_reg_rdata, .background_debug, .mem_req, .mem_we, .mem_be,
      .mem_addr, .mem_wdata, .mem_steal, .debug_rom_sel, .debug_reg_sel,
      .cpu_reg_sel, .cpu_reg_we, .cpu_reg_wdata, .resume, .single_step,
      .tag_enable);
   swd_host swd_host_inst (.clk, .rst_n, .link(link_if), .cmd_valid,
      .cmd_op, .cmd_addr, .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_data);
   swd_link_checker swd_link_checker_inst (.clk, .rst_n,
      .host_o(link_if.host_o), .host_oe(link_if.host_oe),
      .dev_o(link_if.dev_o), .dev_oe(link_if.dev_oe),
      .pin_level(link_if.pin_level));
   assign cpu_reg_rdata = cpu_r[cpu_reg_sel];
   ////////////////////////
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   // debug windows while mapped in
   function automatic logic win(input logic [15:0] x);
      win = x >= 16'hFF20 || (x >= 16'hFF00 && x <= 16'hFF06);
   endfunction : win
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done
   task automatic send(input logic [7:0] o, input logic [15:0] x,
      input logic [15:0] y);
      int t;
      cmd_valid = 1'b1;
      cmd_op = o;
      cmd_addr = x;
      cmd_wdata = y;
      t = 0;
      while (cmd_ready !== 1'b1 && t < 3000)
      begin
         @(posedge clk);
         #1;
         t++;
      end
      @(posedge clk);
      #1;
      cmd_valid = 1'b0;
      do
      begin
         @(posedge clk);
         #1;
         t++;
      end while (cmd_ready !== 1'b1 && t < 6000);
      if (cmd_ready !== 1'b1)
         miscompares++;
   endtask : send
   task automatic hw(input logic [7:0] o, input logic [15:0] x,
      input logic [15:0] y);
      logic [15:0] w;
      logic [15:0] v;
      w = {win(x) && (o[2] || bg), x[15:1]};
      v = shd[w];
      if (!o[5] && o[3])
         v = y;
      if (!o[5] && !o[3])
         v = x[0] ? {v[15:8], y[7:0]} : {y[15:8], v[7:0]};
      shd[w] = v;
      if (o[5] && !o[3])
         v = x[0] ? {8'h00, v[7:0]} : {v[15:8], 8'h00};
      if (o[5])
         expq.push_back(v);
      send(o, x, y);
   endtask : hw
   task automatic fw(input logic [7:0] o, input logic [15:0] y,
      input logic [15:0] x);
      if (o[5])
         expq.push_back(x);
      send(o, 16'h0000, y);
   endtask : fw
   ////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // memory, cpu registers and bus activity
   always @(posedge clk)
   begin
      #1;
      rnd = lfsr(rnd);
      bus_free = rnd[0] && !hold_bus;
      cpu_break = single_step;
      n_res += resume;
      n_step += single_step;
      n_tag += tag_enable;
      if (cpu_reg_we)
         cpu_r[cpu_reg_sel] = cpu_reg_wdata;
      mw = {debug_rom_sel | debug_reg_sel, mem_addr[15:1]};
      if (mem_req && !mem_ack && (rnd[1] || rnd[2] || hold_bus))
      begin
         if (mem_we && mem_be[1])
            mem[mw][15:8] = mem_wdata[15:8];
         if (mem_we && mem_be[0])
            mem[mw][7:0] = mem_wdata[7:0];
         mem_rdata = mem[mw];
         steal_seen |= mem_steal;
         n_acc++;
         mem_ack = 1'b1;
      end
      else
      begin
         mem_rdata = ~mem_rdata;
         mem_ack = 1'b0;
      end
   end
   always @(negedge clk)
      if (rsp_valid === 1'b1)
      begin
         e = expq.size() > 0 ? expq.pop_front() : 16'hXXXX;
         `CHK(rsp_data, e)
      end
   // hang guard
   initial
   begin
      #720000;
      miscompares++;
      test_done();
   end
   initial
   begin
      {rst_n, cmd_valid, cmd_op, cmd_addr, cmd_wdata} = '0;
      {firmware_debug_enable, cpu_break, bus_free, mem_ack} = '0;
      {mem_rdata, bg, hold_bus, steal_seen} = '0;
      rnd = 16'h0034;
      foreach (cpu_r[i])
         cpu_r[i] = 16'h0000;
      for (int i = 0; i < 65536; i++)
      begin
         mem[i] = 16'(i * 40503);
         shd[i] = mem[i];
      end
      repeat (20) @(posedge clk);
      #1;
      rst_n = 1'b1;
      // every memory command, reads crossing the map
      for (int i = 0; i < 16; i++)
      begin
         hold_bus = (i == 9);
         a = {rnd[3] ? 8'hFF : rnd[15:8], rnd[11:4]};
         op = 8'hC0 | {4'h0, i[1:0], 2'h0};
         if (op[3])
            a[0] = 1'b0;
         if (a[15:1] == 15'h7F83)
            a = 16'hFF04;
         hw(op, a, {rnd[7:0], rnd[15:8]});
         hw(op ^ 8'h20 ^ {5'h00, i[2], 2'h0}, a, 16'h0000);
         if (i == 8)
            `CHK(steal_seen, 1'b0)
      end
      hold_bus = 1'b0;
      `CHK(steal_seen, 1'b1)
      fw(8'h65, 16'h0000, 16'hFFFF);
      send(8'h90, 16'h0000, 16'h0000);
      `CHK(background_debug, 1'b0)
      k = n_acc;
      send(8'h55, 16'h0000, 16'h0000);
      `CHK(n_acc, k)
      firmware_debug_enable = 1'b1;
      send(8'h90, 16'h0000, 16'h0000);
      bg = 1'b1;
      `CHK(background_debug, 1'b1)
      for (int r = 3; r < 8; r++)
      begin
         d = rnd;
         fw(8'h40 | 8'(r), d, 16'h0000);
         fw(8'h60 | 8'(r), 16'h0000, d);
      end
      fw(8'h45, 16'h1000, 16'h0000);
      fw(8'h42, 16'hBEEF, 16'h0000);
      shd[16'h0801] = 16'hBEEF;
      fw(8'h45, 16'h1000, 16'h0000);
      fw(8'h62, 16'h0000, 16'hBEEF);
      fw(8'h65, 16'h0000, 16'h1002);
      hw(8'hE8, 16'hFF20, 16'h0000);
      hw(8'hE0, 16'hFF01, 16'h0000);
      send(8'h10, 16'h0000, 16'h0000);
      `CHK(n_step, 1)
      `CHK(background_debug, 1'b1)
      send(8'h08, 16'h0000, 16'h0000);
      `CHK(n_res, 1)
      `CHK(background_debug, 1'b0)
      // half-sent command must be dropped on silence
      fw(8'h45, 16'hE8E8, 16'h0000);
      repeat (600) @(posedge clk);
      #1;
      fw(8'h63, 16'h0000, 16'hFFFF);
      send(8'h90, 16'h0000, 16'h0000);
      send(8'h18, 16'h0000, 16'h0000);
      `CHK(n_res, 2)
      `CHK(n_tag, 1)
      repeat (10) @(posedge clk);
      `CHK(expq.size(), 0)
      test_done();
   end
endmodule : testbench
